// ---- sits_pkg.sv ----
// Purpose: shared constants for the supervisor interrupt and trap select block
// Assumes: register bus with 3-bit word address, data SXLEN wide
// Notes:   bit positions follow the interrupt cause numbers

// ****************************************************************************
// package
// ****************************************************************************
package sits_pkg;
    // register word addresses
    localparam logic [2:0] OFF_PEND   = 3'h0;
    localparam logic [2:0] OFF_ENAB   = 3'h1;
    localparam logic [2:0] OFF_TVEC   = 3'h2;
    localparam logic [2:0] OFF_STAT   = 3'h3;
    localparam logic [2:0] OFF_TRAP   = 3'h4;
    // standard interrupt bit positions, equal to their cause numbers
    localparam int         BIT_SOFT   = 1;
    localparam int         BIT_TIMER  = 5;
    localparam int         BIT_EXT    = 9;
    localparam int         BIT_OVF    = 13;
    localparam int         STD_BITS   = 16;
    // machine software, timer and external positions, never delegated here
    localparam logic [15:0] MACH_MASK = 16'h0888;
    // positions a supervisor interrupt may occupy at all
    localparam logic [15:0] SUPV_MASK = 16'h2222;
    // pending bits software may write
    localparam logic [15:0] SW_PEND_MASK = 16'h2002;
    // status register fields
    localparam int         ST_GIE     = 1;
    localparam int         ST_PGIE    = 5;
    // trap status register fields
    localparam int         TR_REQ     = 4;
    // vector mode encodings
    localparam logic [1:0] MODE_DIRECT   = 2'h0;
    localparam logic [1:0] MODE_VECTORED = 2'h1;
    // privilege codes seen on the privilege input
    localparam logic [1:0] PRIV_U     = 2'h0;
    localparam logic [1:0] PRIV_S     = 2'h1;
    // values after reset
    localparam logic [15:0] PEND_RST  = 16'h0000;
    localparam logic [15:0] ENAB_RST  = 16'h0000;
    localparam logic [1:0] MODE_RST   = 2'h0;
    localparam logic       GIE_RST    = 1'b0;
    localparam logic       PGIE_RST   = 1'b0;
    localparam int         CAUSE_W    = 4;
endpackage

// ---- sits_trap_if.sv ----
// Purpose: carries active interrupts, selection and vector data between modules
// Assumes: one core, one priority picker, one vector calculator
// Notes:   purely combinational signals

`timescale 1ns/1ns

// ****************************************************************************
// interface
// ****************************************************************************
interface sits_trap_if #(parameter int SXLEN = 64);
    logic [15:0]       active;
    logic              hit;
    logic [3:0]        cause;
    logic [SXLEN-1:0]  base;
    logic [1:0]        mode;
    logic [SXLEN-1:0]  target;

    modport core (output active, output base, output mode,
                  input hit, input cause, input target);
    modport prio (input active, output hit, output cause);
    modport vect (input base, input mode, input cause, input hit, output target);
endinterface

// ---- sits_prio.sv ----
// Purpose: picks one supervisor interrupt out of the active set
// Assumes: active bits already gated by pending, enable and privilege
// Notes:   fixed order external, software, timer, overflow

`timescale 1ns/1ns

// ****************************************************************************
// priority picker
// ****************************************************************************
module sits_prio (
    sits_trap_if.prio sel
);
    // fixed descending order; cause number equals the bit position
    always_comb begin
        sel.hit   = 1'b1;
        sel.cause = 4'h0;
        if (sel.active[sits_pkg::BIT_EXT]) begin
            sel.cause = 4'(sits_pkg::BIT_EXT);
        end else if (sel.active[sits_pkg::BIT_SOFT]) begin
            sel.cause = 4'(sits_pkg::BIT_SOFT);
        end else if (sel.active[sits_pkg::BIT_TIMER]) begin
            sel.cause = 4'(sits_pkg::BIT_TIMER);
        end else if (sel.active[sits_pkg::BIT_OVF]) begin
            sel.cause = 4'(sits_pkg::BIT_OVF);
        end else begin
            sel.hit = 1'b0;
        end
    end
endmodule

// ---- sits_vect.sv ----
// Purpose: forms the interrupt trap target from base, mode and cause
// Assumes: base arrives with its two low bits already zero
// Notes:   exceptions always use the plain base, formed in the core

`timescale 1ns/1ns

// ****************************************************************************
// vector calculator
// ****************************************************************************
module sits_vect (
    sits_trap_if.vect sel
);
    localparam int W = $bits(sel.base);

    // direct: base for everything; vectored: base plus four times cause
    always_comb begin
        sel.target = sel.base;
        if (sel.mode == sits_pkg::MODE_VECTORED && sel.hit) begin
            sel.target = {sel.base[W-1:2] + (W-2)'(sel.cause), 2'b00};
        end
    end
endmodule

// ---- sits_top.sv ----
// Purpose: supervisor interrupt pending, enable, vector and trap select logic
// Assumes: inputs synchronous to CLK; register strobes one cycle, never both
// Notes:   pending and enable storage is local to this block; no machine-level view exists here
//
// Implementation choices: the register offsets and the address-and-strobe port.

`timescale 1ns/1ns

// ****************************************************************************
// top module
// ****************************************************************************
// How it works
// - direct mode sends every trap to base
// - vectored interrupts go to base plus four times cause
// - base low two bits always zero
// - cause number i maps to bit i
// - trap needs pending, enable and privilege eligibility
// - trap condition re-evaluated every cycle
// - supervisor interrupts outrank lower privilege interrupts
// - writing zero clears a writable pending bit
// - read-only pending bits cleared by environment inputs
// - enable writable when implemented, else reads zero
// - external pending at bit 9, environment driven
// - timer pending at bit 5, environment driven
// - software pending at bit 1, writable, settable externally
// - overflow pending at bit 13, read-write, event set
// - unimplemented bits read zero; enable readback shows implemented
// - registers are views of machine pending and enable; this block keeps its own pend and enab registers instead
// - machine bits 3, 7, 11 read zero
// - order external, software, timer, overflow
module sits_top #(
    parameter int          SXLEN     = 64,
    parameter logic [15:0] IMPL_MASK = 16'h2222
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              CE,
    input  wire logic [2:0]        ADDR,
    input  wire logic [SXLEN-1:0]  WDATA,
    input  wire logic              WE,
    input  wire logic              RE,
    output logic      [SXLEN-1:0]  RDATA,
    input  wire logic [1:0]        PRIV,
    input  wire logic              EXT_IRQ,
    input  wire logic              TIMER_IRQ,
    input  wire logic              SOFT_IRQ_SET,
    input  wire logic              OVF_EVENT,
    input  wire logic              SUPV_RETURN,
    output logic                   IRQ_REQ,
    output logic      [3:0]        IRQ_CAUSE,
    output logic      [SXLEN-1:0]  IRQ_TARGET,
    output logic      [SXLEN-1:0]  EXC_TARGET
);

    // ************************************************************************
    // elaboration checks
    // ************************************************************************
    // only the four standard supervisor causes can be served
    if (SXLEN != 32 && SXLEN != 64) begin : g_bad_width
        $error("SXLEN must be 32 or 64");
    end
    if ((IMPL_MASK & ~sits_pkg::SUPV_MASK) != 16'h0000) begin : g_bad_mask
        $error("IMPL_MASK may only hold bits 1, 5, 9 and 13");
    end

    // ************************************************************************
    // state
    // ************************************************************************
    typedef struct packed {
        logic [15:0]       pend;
        logic [15:0]       enab;
        logic [SXLEN-3:0]  base;
        logic [1:0]        mode;
        logic              gie;
        logic              pgie;
        logic              irq_req;
        logic [3:0]        irq_cause;
        logic [SXLEN-1:0]  irq_target;
        logic [SXLEN-1:0]  exc_target;
        logic [SXLEN-1:0]  rdata;
    } sits_state_type;

    sits_state_type s_r;
    sits_state_type s_nxt;

    sits_trap_if #(.SXLEN(SXLEN)) trap_if ();

    logic        eligible;
    logic [15:0] armed;
    logic        wr_pend;
    logic        wr_enab;
    logic        wr_tvec;
    logic        wr_stat;

    // ************************************************************************
    // helpers
    // ************************************************************************
    // widen a 16-bit standard field to a register word
    function automatic logic [SXLEN-1:0] widen(input logic [15:0] v);
        widen = {{(SXLEN-16){1'b0}}, v};
    endfunction

    // ************************************************************************
    // submodules
    // ************************************************************************
    sits_prio u_prio (
        .sel (trap_if.prio)
    );

    sits_vect u_vect (
        .sel (trap_if.vect)
    );

    // ************************************************************************
    // decode and trap condition
    // ************************************************************************
    // write strobes per register
    assign wr_pend = WE && ADDR == sits_pkg::OFF_PEND;
    assign wr_enab = WE && ADDR == sits_pkg::OFF_ENAB;
    assign wr_tvec = WE && ADDR == sits_pkg::OFF_TVEC;
    assign wr_stat = WE && ADDR == sits_pkg::OFF_STAT;

    // supervisor with global enable, or user mode; machine mode never traps here
    assign eligible = (PRIV == sits_pkg::PRIV_S && s_r.gie) || PRIV == sits_pkg::PRIV_U;
    // lower-privilege interrupts do not exist, so any supervisor one wins
    assign armed    = s_r.pend & s_r.enab & IMPL_MASK;

    // feed picker and vector calculator from registered state and the PRIV input
    assign trap_if.active = eligible ? armed : 16'h0000;
    assign trap_if.base   = {s_r.base, 2'b00};
    assign trap_if.mode   = s_r.mode;

    // ************************************************************************
    // next state
    // ************************************************************************
    always_comb begin
        s_nxt = s_r;
        // environment-driven levels, read-only to software
        s_nxt.pend[sits_pkg::BIT_EXT]   = EXT_IRQ & IMPL_MASK[sits_pkg::BIT_EXT];
        s_nxt.pend[sits_pkg::BIT_TIMER] = TIMER_IRQ & IMPL_MASK[sits_pkg::BIT_TIMER];
        // software may write soft and overflow bits, zero clears
        if (wr_pend) begin
            s_nxt.pend[sits_pkg::BIT_SOFT] = WDATA[sits_pkg::BIT_SOFT]
                                             & IMPL_MASK[sits_pkg::BIT_SOFT];
            s_nxt.pend[sits_pkg::BIT_OVF]  = WDATA[sits_pkg::BIT_OVF]
                                             & IMPL_MASK[sits_pkg::BIT_OVF];
        end
        // hardware set wins over a same-cycle software clear
        if (SOFT_IRQ_SET && IMPL_MASK[sits_pkg::BIT_SOFT]) begin
            s_nxt.pend[sits_pkg::BIT_SOFT] = 1'b1;
        end
        if (OVF_EVENT && IMPL_MASK[sits_pkg::BIT_OVF]) begin
            s_nxt.pend[sits_pkg::BIT_OVF] = 1'b1;
        end
        // enable bits stick only where implemented
        if (wr_enab) begin
            s_nxt.enab = WDATA[15:0] & IMPL_MASK;
        end
        // vector base and mode; reserved modes leave the old mode
        if (wr_tvec) begin
            s_nxt.base = WDATA[SXLEN-1:2];
            if (WDATA[1:0] == sits_pkg::MODE_DIRECT || WDATA[1:0] == sits_pkg::MODE_VECTORED) begin
                s_nxt.mode = WDATA[1:0];
            end
        end
        // global enable and its saved copy
        if (wr_stat) begin
            s_nxt.gie  = WDATA[sits_pkg::ST_GIE];
            s_nxt.pgie = WDATA[sits_pkg::ST_PGIE];
        end
        // supervisor return restores the saved enable
        if (SUPV_RETURN) begin
            s_nxt.gie  = s_r.pgie;
            s_nxt.pgie = 1'b1;
        end
        // trap request and targets, refreshed every cycle
        s_nxt.irq_req    = trap_if.hit;
        s_nxt.irq_cause  = trap_if.cause;
        s_nxt.irq_target = trap_if.target;
        s_nxt.exc_target = {s_r.base, 2'b00};
        // read data stand for exactly one cycle
        s_nxt.rdata = '0;
        if (RE) begin
            unique case (ADDR)
                sits_pkg::OFF_PEND: s_nxt.rdata = widen(s_r.pend & IMPL_MASK);
                sits_pkg::OFF_ENAB: s_nxt.rdata = widen(s_r.enab);
                sits_pkg::OFF_TVEC: s_nxt.rdata = {s_r.base, s_r.mode};
                sits_pkg::OFF_STAT: begin
                    s_nxt.rdata[sits_pkg::ST_GIE]  = s_r.gie;
                    s_nxt.rdata[sits_pkg::ST_PGIE] = s_r.pgie;
                end
                sits_pkg::OFF_TRAP: begin
                    s_nxt.rdata[3:0]              = s_r.irq_cause;
                    s_nxt.rdata[sits_pkg::TR_REQ] = s_r.irq_req;
                end
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    // ************************************************************************
    // registers
    // ************************************************************************
    // all state frozen while CE is low
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r            <= '0;
            s_r.pend       <= sits_pkg::PEND_RST;
            s_r.enab       <= sits_pkg::ENAB_RST;
            s_r.mode       <= sits_pkg::MODE_RST;
            s_r.gie        <= sits_pkg::GIE_RST;
            s_r.pgie       <= sits_pkg::PGIE_RST;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign RDATA      = s_r.rdata;
    assign IRQ_REQ    = s_r.irq_req;
    assign IRQ_CAUSE  = s_r.irq_cause;
    assign IRQ_TARGET = s_r.irq_target;
    assign EXC_TARGET = s_r.exc_target;

    // ************************************************************************
    // assertions
    // ************************************************************************
    logic [SXLEN-3:0] base_q;
    logic [1:0]       mode_q;
    logic [15:0]      pend_q;
    logic [15:0]      enab_q;
    logic [15:0]      active_q;
    logic             gie_q;
    logic             pgie_q;

    // plain copies for sampled-value functions
    assign base_q   = s_r.base;
    assign mode_q   = s_r.mode;
    assign pend_q   = s_r.pend;
    assign enab_q   = s_r.enab;
    assign active_q = trap_if.active;
    assign gie_q    = s_r.gie;
    assign pgie_q   = s_r.pgie;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST || !CE);

    direct_target_a : assert property (
        $past(mode_q) == sits_pkg::MODE_DIRECT && $past(CE)
        |-> IRQ_TARGET == {$past(base_q), 2'b00})
        else $error("direct mode target differs from base");

    vectored_target_a : assert property (
        $past(mode_q) == sits_pkg::MODE_VECTORED && IRQ_REQ && $past(CE)
        |-> IRQ_TARGET == {$past(base_q), 2'b00} + SXLEN'({IRQ_CAUSE, 2'b00})
            && EXC_TARGET == {$past(base_q), 2'b00})
        else $error("vectored target is not base plus four times cause");

    target_aligned_a : assert property (
        IRQ_TARGET[1:0] == 2'b00 && EXC_TARGET[1:0] == 2'b00)
        else $error("trap target not word aligned");

    reserved_mode_a : assert property (
        CE && wr_tvec && WDATA[1] |=> mode_q == $past(mode_q))
        else $error("reserved mode write changed the mode");

    trap_cond_a : assert property (
        $past(CE) |-> IRQ_REQ == ($past(active_q) != 16'h0000))
        else $error("trap request disagrees with its condition");

    ext_first_a : assert property (
        CE && active_q[sits_pkg::BIT_EXT] |=> IRQ_REQ && IRQ_CAUSE == 4'h9)
        else $error("external interrupt lost its precedence");

    soft_before_timer_a : assert property (
        CE && !active_q[sits_pkg::BIT_EXT] && active_q[sits_pkg::BIT_SOFT]
        |=> IRQ_CAUSE == 4'h1)
        else $error("software interrupt lost its precedence");

    soft_set_wins_a : assert property (
        CE && SOFT_IRQ_SET && IMPL_MASK[sits_pkg::BIT_SOFT]
        |=> pend_q[sits_pkg::BIT_SOFT])
        else $error("software pending set was lost");

    write_clear_a : assert property (
        CE && wr_pend && !WDATA[sits_pkg::BIT_OVF] && !OVF_EVENT
        |=> !pend_q[sits_pkg::BIT_OVF])
        else $error("writing zero did not clear overflow pending");

    ext_follows_a : assert property (
        CE |=> pend_q[sits_pkg::BIT_EXT] == $past(EXT_IRQ & IMPL_MASK[sits_pkg::BIT_EXT]))
        else $error("external pending does not follow its input");

    enable_mask_a : assert property (
        (enab_q & ~IMPL_MASK) == 16'h0000 && (enab_q & sits_pkg::MACH_MASK) == 16'h0000)
        else $error("unimplemented enable bit is set");

    pend_read_a : assert property (
        CE && RE && ADDR == sits_pkg::OFF_PEND
        |=> RDATA == widen($past(pend_q) & IMPL_MASK) ##1 (RDATA == '0 || $past(RE)))
        else $error("pending read data wrong or held too long");

    bounded_eval_a : assert property (
        CE && TIMER_IRQ && IMPL_MASK[sits_pkg::BIT_TIMER] && PRIV == sits_pkg::PRIV_U
        ##1 PRIV == sits_pkg::PRIV_U && CE && enab_q[sits_pkg::BIT_TIMER]
        |=> IRQ_REQ)
        else $error("pending timer interrupt not raised within two cycles");

    timer_follows_a : assert property (
        CE |=> pend_q[sits_pkg::BIT_TIMER]
               == $past(TIMER_IRQ & IMPL_MASK[sits_pkg::BIT_TIMER]))
        else $error("timer pending does not follow its input");

    ovf_set_wins_a : assert property (
        CE && OVF_EVENT && IMPL_MASK[sits_pkg::BIT_OVF]
        |=> pend_q[sits_pkg::BIT_OVF])
        else $error("overflow pending set was lost");

    mode_legal_a : assert property (
        !mode_q[1])
        else $error("vector mode holds a reserved value");

    pend_mask_a : assert property (
        (pend_q & ~IMPL_MASK) == 16'h0000 && (pend_q & sits_pkg::MACH_MASK) == 16'h0000)
        else $error("unimplemented pending bit is set");

    machine_blocks_a : assert property (
        CE && PRIV[1] |=> !IRQ_REQ)
        else $error("request raised above supervisor privilege");

    cause_idle_a : assert property (
        !IRQ_REQ |-> IRQ_CAUSE == 4'h0)
        else $error("cause shown without a request");

    enable_write_a : assert property (
        CE && wr_enab |=> enab_q == ($past(WDATA[15:0]) & IMPL_MASK))
        else $error("enable write did not land masked");

    return_restore_a : assert property (
        CE && SUPV_RETURN |=> gie_q == $past(pgie_q) && pgie_q)
        else $error("supervisor return did not restore the enable");

    vectored_trap_c : cover property (
        mode_q == sits_pkg::MODE_VECTORED ##1 IRQ_REQ);

    ext_soft_clash_c : cover property (
        active_q[sits_pkg::BIT_EXT] && active_q[sits_pkg::BIT_SOFT]);

    reserved_write_c : cover property (wr_tvec && WDATA[1]);

    return_wakeup_c : cover property (SUPV_RETURN ##2 IRQ_REQ);

endmodule

// ---- sits_env_model.sv ----
// Purpose: model of the platform interrupt controller and execution environment
// Assumes: driven from the bench through its tasks, all changes at a rising edge
// Notes:   levels stay until changed; set requests are one-cycle pulses

`timescale 1ns/1ns

// ****************************************************************************
// environment model
// ****************************************************************************
module sits_env_model (
    input  wire logic clk,
    output logic      ext_irq,
    output logic      timer_irq,
    output logic      soft_irq_set,
    output logic      ovf_event
);
    // quiet after time zero
    initial begin
        ext_irq      = 1'b0;
        timer_irq    = 1'b0;
        soft_irq_set = 1'b0;
        ovf_event    = 1'b0;
    end

    // environment alone raises and drops the external and timer levels
    task automatic set_levels(input logic ext, input logic tim);
        @(posedge clk);
        ext_irq   <= ext;
        timer_irq <= tim;
    endtask

    // one-cycle set request after a chosen delay: 0 software, 1 overflow
    task automatic pulse(input logic which, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        if (which) begin
            ovf_event <= 1'b1;
        end else begin
            soft_irq_set <= 1'b1;
        end
        @(posedge clk);
        ovf_event    <= 1'b0;
        soft_irq_set <= 1'b0;
    endtask
endmodule

// ---- sits_top_test.sv ----
// Purpose: self-checking bench for the supervisor interrupt block
// Assumes: default SXLEN and IMPL_MASK
// Notes:   waits are fixed cycle counts from the hand-over latencies

`timescale 1ns/1ns

// ****************************************************************************
// testbench
// ****************************************************************************
module sits_top_test;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        ce    = 1'b1;
    logic [2:0]  addr  = 3'h0;
    logic [63:0] wdata = 64'h0;
    logic        we    = 1'b0;
    logic        re    = 1'b0;
    logic [1:0]  priv  = 2'h0;
    logic        supv_return_instr  = 1'b0;
    logic [63:0] rdata;
    logic [63:0] itgt;
    logic [63:0] etgt;
    logic        ireq;
    logic [3:0]  icause;
    logic        ext;
    logic        tim;
    logic        sset;
    logic        ovf;
    int          err_total  = 0;
    int          n_compared = 0;

    // clock of 100 ns period
    always #50 clk = ~clk;

    sits_top DUT (.CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WE(we),
        .RE(re), .RDATA(rdata), .PRIV(priv), .EXT_IRQ(ext), .TIMER_IRQ(tim),
        .SOFT_IRQ_SET(sset), .OVF_EVENT(ovf), .SUPV_RETURN(supv_return_instr), .IRQ_REQ(ireq),
        .IRQ_CAUSE(icause), .IRQ_TARGET(itgt), .EXC_TARGET(etgt));

    sits_env_model env (.clk(clk), .ext_irq(ext), .timer_irq(tim),
        .soft_irq_set(sset), .ovf_event(ovf));

    // ************************************************************************
    // helpers
    // ************************************************************************
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            err_total++;
        end
    endtask

    // one-cycle register write
    task automatic wr(input logic [2:0] a, input logic [63:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    // one-cycle read, data checked in the following cycle
    task automatic rd(input logic [2:0] a, input logic [63:0] e);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    // request, cause and target after n edges
    task automatic look(input int n, input logic r, input logic [3:0] c,
                        input logic [63:0] t);
        repeat (n) @(posedge clk);
        #1;
        chk({63'h0, ireq}, {63'h0, r});
        chk({60'h0, icause}, {60'h0, c});
        if (r) chk(itgt, t);
    endtask

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        stop_test();
    end

    // ************************************************************************
    // main sequence
    // ************************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // every word reads zero after reset, unmapped ones too
        for (int a = 0; a < 8; a++) rd(a[2:0], 64'h0);
        wr(3'h5, {64{1'b1}});
        rd(3'h5, 64'h0);
        wr(sits_pkg::OFF_ENAB, {64{1'b1}});
        rd(sits_pkg::OFF_ENAB, 64'h2222);
        wr(sits_pkg::OFF_PEND, {64{1'b1}});
        rd(sits_pkg::OFF_PEND, 64'h2002);
        look(2, 1'b1, 4'h1, 64'h0);
        wr(sits_pkg::OFF_PEND, 64'h0);
        look(2, 1'b0, 4'h0, 64'h0);
        // external level, exact latency
        env.set_levels(1'b1, 1'b0);
        look(1, 1'b0, 4'h0, 64'h0);
        look(1, 1'b1, 4'h9, 64'h0);
        rd(sits_pkg::OFF_TRAP, 64'h19);
        env.set_levels(1'b1, 1'b1);
        env.pulse(1'b0, 0);
        env.pulse(1'b1, 3);
        rd(sits_pkg::OFF_PEND, 64'h2222);
        // vectored targets while walking down the priority order
        wr(sits_pkg::OFF_TVEC, 64'h1001);
        look(2, 1'b1, 4'h9, 64'h1024);
        chk(etgt, 64'h1000);
        wr(sits_pkg::OFF_TVEC, 64'h4003);
        rd(sits_pkg::OFF_TVEC, 64'h4001);
        env.set_levels(1'b0, 1'b1);
        look(2, 1'b1, 4'h1, 64'h4004);
        wr(sits_pkg::OFF_PEND, 64'h2000);
        look(2, 1'b1, 4'h5, 64'h4014);
        env.set_levels(1'b0, 1'b0);
        look(2, 1'b1, 4'hD, 64'h4034);
        chk(etgt, 64'h4000);
        wr(sits_pkg::OFF_PEND, 64'h0);
        look(2, 1'b0, 4'h0, 64'h0);
        wr(sits_pkg::OFF_TVEC, 64'h4000);
        env.pulse(1'b0, 0);
        look(2, 1'b1, 4'h1, 64'h4000);
        // privilege and global enable
        @(posedge clk);
        priv <= sits_pkg::PRIV_S;
        look(2, 1'b0, 4'h0, 64'h0);
        wr(sits_pkg::OFF_STAT, 64'h2);
        look(1, 1'b1, 4'h1, 64'h4000);
        @(posedge clk);
        priv <= 2'h3;
        look(2, 1'b0, 4'h0, 64'h0);
        @(posedge clk);
        priv <= sits_pkg::PRIV_S;
        supv_return_instr <= 1'b1;
        @(posedge clk);
        supv_return_instr <= 1'b0;
        look(2, 1'b0, 4'h0, 64'h0);
        rd(sits_pkg::OFF_STAT, 64'h20);
        // frozen while the clock enable is low
        @(posedge clk);
        priv <= sits_pkg::PRIV_U;
        ce   <= 1'b0;
        wr(sits_pkg::OFF_ENAB, 64'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd(sits_pkg::OFF_ENAB, 64'h2222);
        look(2, 1'b1, 4'h1, 64'h4000);
        wr(sits_pkg::OFF_ENAB, 64'h0);
        look(1, 1'b0, 4'h0, 64'h0);
        stop_test();
    end
endmodule
